// file: src/uas_pkg.sv
package uas_pkg;
    // Register byte offsets
    localparam logic [7:0] UAS_OFF_MODE = 8'h00;
    localparam logic [7:0] UAS_OFF_BAUD = 8'h04;
    localparam logic [7:0] UAS_OFF_TXD = 8'h08;
    localparam logic [7:0] UAS_OFF_RXB = 8'h0C;
    localparam logic [7:0] UAS_OFF_ERR = 8'h10;
    localparam logic [7:0] UAS_OFF_STAT = 8'h14;
    // Mode register fields
    localparam int UAS_MODE_POWER = 7;
    localparam int UAS_MODE_TXEN = 6;
    localparam int UAS_MODE_RXEN = 5;
    localparam int UAS_MODE_PS_HI = 4;
    localparam int UAS_MODE_PS_LO = 3;
    localparam int UAS_MODE_CL = 2;
    localparam int UAS_MODE_SL = 1;
    localparam logic [7:0] UAS_MODE_RST = 8'h01;
    // Baud divider register fields
    localparam int UAS_BAUD_SEL_HI = 7;
    localparam int UAS_BAUD_SEL_LO = 6;
    localparam int UAS_BAUD_K_HI = 4;
    localparam logic [7:0] UAS_BAUD_RST = 8'h1F;
    // Error status fields
    localparam int UAS_ERR_PE = 2;
    localparam int UAS_ERR_FE = 1;
    localparam int UAS_ERR_OVE = 0;
    // Parity modes
    localparam logic [1:0] UAS_PAR_NONE = 2'h0;
    localparam logic [1:0] UAS_PAR_ZERO = 2'h1;
    localparam logic [1:0] UAS_PAR_ODD = 2'h2;
    localparam logic [1:0] UAS_PAR_EVEN = 2'h3;
    // Clock select codes
    localparam logic [1:0] UAS_SEL_TIMER = 2'h0;
    localparam logic [1:0] UAS_SEL_DIV2 = 2'h1;
    localparam logic [1:0] UAS_SEL_DIV8 = 2'h2;
    localparam logic [1:0] UAS_SEL_DIV32 = 2'h3;
    localparam logic [1:0] UAS_RESP_OKAY = 2'h0;
    localparam logic [1:0] UAS_RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        UAS_TX_IDLE = 5'h01,
        UAS_TX_START = 5'h02,
        UAS_TX_DATA = 5'h04,
        UAS_TX_PAR = 5'h08,
        UAS_TX_STOP = 5'h10
    } uas_tx_e;

    typedef enum logic [4:0] {
        UAS_RX_IDLE = 5'h01,
        UAS_RX_CHECK = 5'h02,
        UAS_RX_DATA = 5'h04,
        UAS_RX_PAR = 5'h08,
        UAS_RX_STOP = 5'h10
    } uas_rx_e;
endpackage

// file: src/uas_baud_cnt.sv
`timescale 1ns/1ns
module uas_baud_cnt
    import uas_pkg::*;
#(
    parameter int KW = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic clear,
    input wire logic base_tick,
    input wire logic [KW-1:0] k,
    // Pulses
    output logic half_tick,
    output logic bit_tick
);
    logic [KW-1:0] cnt_q;
    logic half_q;
    logic wrap;

    assign wrap = base_tick && (cnt_q == k - 1'b1);
    assign half_tick = wrap;
    assign bit_tick = wrap && half_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            half_q <= 1'b0;
        end else if (clear) begin
            cnt_q <= '0;
            half_q <= 1'b0;
        end else if (wrap) begin
            cnt_q <= '0;
            half_q <= !half_q;
        end else if (base_tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// file: src/uas_top.sv
// How it works
// - Parity none: no parity bit sent or expected, no parity error.
// - Power then transmit enable; writing a byte starts a framed transmission.
// - Frame order: start bit, data LSB first, parity, stop bits.
// - Transmit done pulse right after the last stop bit.
// - After a frame the transmitter idles until new data is written.
// - Receiver samples input only after power and then receive enable.
// - Falling edge starts counter; after k counts low input confirms start.
// - Bits shift in at baud rate; stop bit raises done, fills buffer.
// - Frame completing over unread buffer flags overrun, buffer kept.
// - Parity error does not abort; one done pulse after stop position.
// - Flag parity and framing errors; errors ride on receive done.
// - Receiver checks exactly one stop bit.
// - Reading error status clears all its flags.
// - Two-sample agreement filter on base clock delays reception.
// - Separate 5-bit divide counters for transmit and receive.
// - Base clock chosen by select bits, held off while power is off.
// - Transmit counter cleared while disabled and on a data write to an idle transmitter.
// - Receive counter cleared while disabled, runs from start to frame end.
// - Select 00 timer, 01 div 2, 10 div 8, 11 div 32.
// - Bit rate is base clock over twice k.
// - Mode selects 7/8 bits, parity type, 1 or 2 stop bits.
// - Power off clears unit, error status, transmit and receive registers.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module uas_top
    import uas_pkg::*;
#(
    parameter int KW = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial link and clock source
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    input wire logic timer_output_source,
    // Events
    output logic tx_done_irq,
    output logic rx_done_irq
);
    logic [7:0] mode_q, baud_q, tx_shift_reg_q, rx_shift_reg_q, rx_buffer_reg_q;
    logic [2:0] err_q;
    logic rx_full_q;
    logic [7:0] aw_addr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic uart_power_on, tx_enable_bit, rx_enable_bit, len8, stop2;
    logic [1:0] par_mode, clk_sel;
    logic [KW-1:0] divisor_k_field;
    logic do_wr, wr_tx, rd_hs, rd_rxb, rd_err;
    logic [4:0] pre_q;
    logic timer_q, base_tick;
    logic filt_a_q, filt_b_q, rxf_q, rxf_prev_q;
    uas_tx_e tx_q;
    uas_rx_e rx_q;
    logic [2:0] tx_idx_q, rx_idx_q;
    logic tx_stop2_q, rx_par_q;
    logic tx_bit, rx_half, rx_bit, rx_mid, rx_done;
    logic [2:0] last_idx;

    function automatic logic par_of(input logic [7:0] d, input logic l8, input logic [1:0] pm);
        logic x;
        x = ^d[6:0] ^ (l8 & d[7]);
        case (pm)
            UAS_PAR_ODD: par_of = !x;
            UAS_PAR_EVEN: par_of = x;
            default: par_of = 1'b0;
        endcase
    endfunction

    assign uart_power_on = mode_q[UAS_MODE_POWER];
    assign tx_enable_bit = mode_q[UAS_MODE_TXEN];
    assign rx_enable_bit = mode_q[UAS_MODE_RXEN];
    assign par_mode = mode_q[UAS_MODE_PS_HI:UAS_MODE_PS_LO];
    assign len8 = mode_q[UAS_MODE_CL];
    assign stop2 = mode_q[UAS_MODE_SL];
    assign clk_sel = baud_q[UAS_BAUD_SEL_HI:UAS_BAUD_SEL_LO];
    assign divisor_k_field = baud_q[KW-1:0];
    assign last_idx = len8 ? 3'h7 : 3'h6;

    // Bus strobes
    assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_tx = do_wr && (aw_addr_q == UAS_OFF_TXD) && w_strb_q[0];
    assign rd_hs = s_axi_arvalid && s_axi_arready;
    assign rd_rxb = rd_hs && (s_axi_araddr == UAS_OFF_RXB);
    assign rd_err = rd_hs && (s_axi_araddr == UAS_OFF_ERR);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= UAS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bresp <= (aw_addr_q == UAS_OFF_MODE || aw_addr_q == UAS_OFF_BAUD
                                || aw_addr_q == UAS_OFF_TXD) ? UAS_RESP_OKAY : UAS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= UAS_MODE_RST;
            baud_q <= UAS_BAUD_RST;
        end else if (do_wr && w_strb_q[0]) begin
            if (aw_addr_q == UAS_OFF_MODE) begin
                mode_q <= {w_data_q[7:1], 1'b1};
            end
            if (aw_addr_q == UAS_OFF_BAUD) begin
                baud_q <= {w_data_q[7:6], 1'b0, w_data_q[4:0]};
            end
        end
    end

    // Read channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= UAS_RESP_OKAY;
        end else if (rd_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= UAS_RESP_OKAY;
            case (s_axi_araddr)
                UAS_OFF_MODE: s_axi_rdata <= {24'h000000, mode_q};
                UAS_OFF_BAUD: s_axi_rdata <= {24'h000000, baud_q};
                UAS_OFF_TXD: s_axi_rdata <= {24'h000000, tx_shift_reg_q};
                UAS_OFF_RXB: s_axi_rdata <= {24'h000000, rx_buffer_reg_q};
                UAS_OFF_ERR: s_axi_rdata <= {29'h00000000, err_q};
                UAS_OFF_STAT: s_axi_rdata <= {30'h00000000, tx_q != UAS_TX_IDLE, rx_full_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= UAS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Prescaler and base clock select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= 5'h00;
            timer_q <= 1'b0;
        end else begin
            pre_q <= uart_power_on ? pre_q + 5'h01 : 5'h00;
            timer_q <= timer_output_source;
        end
    end

    always_comb begin
        case (clk_sel)
            UAS_SEL_TIMER: base_tick = timer_output_source && !timer_q;
            UAS_SEL_DIV2: base_tick = pre_q[0];
            UAS_SEL_DIV8: base_tick = &pre_q[2:0];
            UAS_SEL_DIV32: base_tick = &pre_q;
            default: base_tick = 1'b0;
        endcase
        base_tick = base_tick && uart_power_on;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_a_q <= 1'b1;
            filt_b_q <= 1'b1;
            rxf_q <= 1'b1;
            rxf_prev_q <= 1'b1;
        end else if (base_tick) begin
            filt_a_q <= serial_in_pin;
            filt_b_q <= filt_a_q;
            if (filt_a_q == filt_b_q) begin
                rxf_q <= filt_b_q;
            end
            rxf_prev_q <= rxf_q;
        end else if (!uart_power_on) begin
            filt_a_q <= 1'b1;
            filt_b_q <= 1'b1;
            rxf_q <= 1'b1;
            rxf_prev_q <= 1'b1;
        end
    end

    uas_baud_cnt #(.KW(KW)) u_tx_cnt (
        .clk(clk),
        .rst(rst),
        .clear(!(uart_power_on && tx_enable_bit) || (wr_tx && tx_q == UAS_TX_IDLE)),
        .base_tick(base_tick),
        .k(divisor_k_field),
        .half_tick(),
        .bit_tick(tx_bit)
    );

    uas_baud_cnt #(.KW(KW)) u_rx_cnt (
        .clk(clk),
        .rst(rst),
        .clear(!(uart_power_on && rx_enable_bit) || rx_q == UAS_RX_IDLE),
        .base_tick(base_tick),
        .k(divisor_k_field),
        .half_tick(rx_half),
        .bit_tick(rx_bit)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_q <= UAS_TX_IDLE;
            tx_shift_reg_q <= 8'h00;
            tx_idx_q <= 3'h0;
            tx_stop2_q <= 1'b0;
        end else if (!uart_power_on) begin
            tx_q <= UAS_TX_IDLE;
            tx_shift_reg_q <= 8'h00;
        end else if (!tx_enable_bit) begin
            tx_q <= UAS_TX_IDLE;
        end else if (wr_tx && tx_q == UAS_TX_IDLE) begin
            tx_shift_reg_q <= w_data_q[7:0];
            tx_q <= UAS_TX_START;
            tx_idx_q <= 3'h0;
        end else if (tx_bit) begin
            case (tx_q)
                UAS_TX_START: tx_q <= UAS_TX_DATA;
                UAS_TX_DATA: begin
                    tx_idx_q <= tx_idx_q + 3'h1;
                    if (tx_idx_q == last_idx) begin
                        tx_stop2_q <= stop2;
                        tx_q <= (par_mode == UAS_PAR_NONE) ? UAS_TX_STOP : UAS_TX_PAR;
                    end
                end
                UAS_TX_PAR: begin
                    tx_stop2_q <= stop2;
                    tx_q <= UAS_TX_STOP;
                end
                UAS_TX_STOP: begin
                    tx_stop2_q <= 1'b0;
                    if (!tx_stop2_q) begin
                        tx_q <= UAS_TX_IDLE;
                    end
                end
                default: tx_q <= UAS_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_out_pin <= 1'b1;
            tx_done_irq <= 1'b0;
        end else begin
            case (tx_q)
                UAS_TX_START: serial_out_pin <= 1'b0;
                UAS_TX_DATA: serial_out_pin <= tx_shift_reg_q[tx_idx_q];
                UAS_TX_PAR: serial_out_pin <= par_of(tx_shift_reg_q, len8, par_mode);
                default: serial_out_pin <= 1'b1;
            endcase
            // pulse as the last stop bit ends
            tx_done_irq <= tx_bit && tx_q == UAS_TX_STOP && !tx_stop2_q
                           && uart_power_on && tx_enable_bit;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_q <= UAS_RX_IDLE;
            rx_shift_reg_q <= 8'h00;
            rx_idx_q <= 3'h0;
            rx_par_q <= 1'b0;
        end else if (!uart_power_on || !rx_enable_bit) begin
            rx_q <= UAS_RX_IDLE;
        end else begin
            case (rx_q)
                UAS_RX_IDLE: if (base_tick && rxf_prev_q && !rxf_q) begin
                    rx_q <= UAS_RX_CHECK;
                end
                UAS_RX_CHECK: if (rx_half) begin
                    rx_q <= rxf_q ? UAS_RX_IDLE : UAS_RX_DATA;
                    rx_idx_q <= 3'h0;
                    rx_shift_reg_q <= 8'h00;
                end
                UAS_RX_DATA: if (rx_mid) begin
                    rx_shift_reg_q[rx_idx_q] <= rxf_q;
                    rx_idx_q <= rx_idx_q + 3'h1;
                    if (rx_idx_q == last_idx) begin
                        rx_q <= (par_mode == UAS_PAR_NONE) ? UAS_RX_STOP : UAS_RX_PAR;
                    end
                end
                UAS_RX_PAR: if (rx_mid) begin
                    rx_par_q <= rxf_q;
                    rx_q <= UAS_RX_STOP;
                end
                UAS_RX_STOP: if (rx_mid) begin
                    rx_q <= UAS_RX_IDLE;
                end
                default: rx_q <= UAS_RX_IDLE;
            endcase
        end
    end

    // Samples land mid-bit: the wraps that fall between bit ticks
    assign rx_mid = rx_half && !rx_bit;
    assign rx_done = rx_q == UAS_RX_STOP && rx_mid && uart_power_on && rx_enable_bit;

    // completion, buffer and error flags; set beats read-clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_buffer_reg_q <= 8'h00;
            rx_full_q <= 1'b0;
            err_q <= 3'h0;
            rx_done_irq <= 1'b0;
        end else if (!uart_power_on) begin
            rx_buffer_reg_q <= 8'h00;
            rx_full_q <= 1'b0;
            err_q <= 3'h0;
            rx_done_irq <= 1'b0;
        end else begin
            rx_done_irq <= rx_done;
            if (rd_err) begin
                err_q <= 3'h0;
            end
            if (rd_rxb) begin
                rx_full_q <= 1'b0;
            end
            if (rx_done) begin
                // Flags stay set until software reads them
                if (!rxf_q) begin
                    err_q[UAS_ERR_FE] <= 1'b1;
                end
                if ((par_mode == UAS_PAR_ODD || par_mode == UAS_PAR_EVEN)
                    && (par_of(rx_shift_reg_q, len8, par_mode) != rx_par_q)) begin
                    err_q[UAS_ERR_PE] <= 1'b1;
                end
                if (rx_full_q && !rd_rxb) begin
                    err_q[UAS_ERR_OVE] <= 1'b1;
                end else begin
                    rx_buffer_reg_q <= rx_shift_reg_q;
                    rx_full_q <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_last_stop;
        tx_q == UAS_TX_STOP && !tx_stop2_q && tx_bit && tx_enable_bit && uart_power_on;
    endsequence

    a_line_rests_high: assert property (
        $past(tx_q) == UAS_TX_IDLE && tx_q == UAS_TX_IDLE |-> serial_out_pin)
        else $error("serial output low while idle");
    a_start_bit_low: assert property (
        tx_q == UAS_TX_START |=> !serial_out_pin)
        else $error("start bit not low");
    a_tx_done_time: assert property (
        s_last_stop |=> tx_done_irq ##1 !tx_done_irq)
        else $error("transmit done pulse wrong");
    a_tx_stays_idle: assert property (
        tx_q == UAS_TX_IDLE && !wr_tx |=> tx_q == UAS_TX_IDLE)
        else $error("transmitter left idle without data");
    a_no_parity_err: assert property (
        par_mode == UAS_PAR_NONE && rx_done && !err_q[UAS_ERR_PE] |=> !err_q[UAS_ERR_PE])
        else $error("parity error with parity none");
    a_rx_gated_off: assert property (
        !rx_enable_bit |=> rx_q == UAS_RX_IDLE)
        else $error("receiver active while disabled");
    a_overrun_keeps: assert property (
        rx_done && rx_full_q && !rd_rxb |=> $stable(rx_buffer_reg_q) && err_q[UAS_ERR_OVE])
        else $error("overrun overwrote buffer");
    a_err_read_clear: assert property (
        rd_err && !rx_done |=> err_q == 3'h0)
        else $error("error status not cleared by read");
    a_base_held_off: assert property (
        !uart_power_on |-> !base_tick)
        else $error("base clock runs with power off");
    a_start_confirm: assert property (
        rx_q == UAS_RX_CHECK && rx_half && rxf_q |=> rx_q == UAS_RX_IDLE)
        else $error("high level accepted as start bit");
endmodule

// file: sim/uas_remote.sv
`timescale 1ns/1ns
module uas_remote #(
    parameter int BIT_CLK = 32
) (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic line_from_dut,
    output logic line_to_dut
);
    initial line_to_dut = 1'b1;

    // bit period: sends n bits, index 0 first, then rests high
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line_to_dut <= f[i];
            repeat (BIT_CLK) @(posedge clk);
        end
        line_to_dut <= 1'b1;
        // Idle for a clock so the next frame never drives the line twice in a step
        @(posedge clk);
    endtask

    // frame order: samples n bits at their centres
    task automatic recv(input int n, output logic [11:0] f);
        f = 12'h000;
        @(negedge line_from_dut);
        repeat (BIT_CLK / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            f[i] = line_from_dut;
            if (i < n - 1) repeat (BIT_CLK) @(posedge clk);
        end
    endtask
endmodule

// file: sim/async_serial_transceiver_test.sv
`timescale 1ns/1ns
module async_serial_transceiver_test;
    import uas_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic tmr = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sin, sout, txd_irq, rxd_irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;

    always #4 clk = ~clk;

    // Timer source: one rising edge every two clocks
    always @(posedge clk) tmr <= ~tmr;

    uas_top #(.KW(5)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_in_pin(sin), .serial_out_pin(sout), .timer_output_source(tmr),
        .tx_done_irq(txd_irq), .rx_done_irq(rxd_irq));

    uas_remote #(.BIT_CLK(32)) rem (.clk(clk), .line_from_dut(sout), .line_to_dut(sin));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (!bvalid) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(n, {r, d}, {UAS_RESP_OKAY, 24'h000000, e});
    endtask

    // Waits for a done pulse; exp says whether one should come
    task automatic wpulse(input logic sel, input int lim, input logic exp);
        int c = 0;
        while (!(sel ? rxd_irq : txd_irq) && c < lim) begin
            @(posedge clk);
            c++;
        end
        chk(sel ? "rx done" : "tx done", c < lim, exp);
    endtask

    task automatic reg_checks();
        logic [31:0] d;
        logic [1:0] r;
        rdc(UAS_OFF_MODE, UAS_MODE_RST, "mode reset");
        rdc(UAS_OFF_BAUD, UAS_BAUD_RST, "baud reset");
        rd(8'h18, d, r);
        chk("unmapped read", r, UAS_RESP_SLVERR);
        wr(UAS_OFF_STAT, 8'h03, r);
        chk("read-only write", r, UAS_RESP_SLVERR);
        wr(UAS_OFF_BAUD, 8'h48, r);
        rdc(UAS_OFF_BAUD, 8'h48, "baud");
    endtask

    task automatic tx_case(input logic [7:0] m, input logic [7:0] d, input int n, input logic [11:0] e);
        logic [11:0] f;
        logic [1:0] r;
        int hi = 0;
        wr(UAS_OFF_MODE, m, r);
        fork
            wr(UAS_OFF_TXD, d, r);
            rem.recv(n, f);
        join
        chk("tx frame", f, e);
        wpulse(1'b0, 40, 1'b1);
        repeat (100) begin
            @(posedge clk);
            hi += sout;
        end
        chk("tx idle", hi, 100);
    endtask

    task automatic rx_frame(input logic [11:0] f, input logic exp);
        fork
            rem.send(f, 11);
            wpulse(1'b1, 450, exp);
        join
    endtask

    task automatic rx_tests();
        logic [1:0] r;
        wr(UAS_OFF_MODE, 8'hDC, r);
        rx_frame({1'b1, ^8'hA5, 8'hA5, 1'b0}, 1'b0);
        wr(UAS_OFF_MODE, 8'hFC, r);
        rx_frame({1'b1, ^8'hA5, 8'hA5, 1'b0}, 1'b1);
        rdc(UAS_OFF_ERR, 8'h00, "clean status");
        rdc(UAS_OFF_RXB, 8'hA5, "rx data");
        rx_frame({1'b1, ~^8'h3C, 8'h3C, 1'b0}, 1'b1);
        rdc(UAS_OFF_ERR, 8'h04, "parity flag");
        rdc(UAS_OFF_ERR, 8'h00, "read clears");
        rdc(UAS_OFF_RXB, 8'h3C, "parity data");
        rx_frame({1'b0, ^8'h5A, 8'h5A, 1'b0}, 1'b1);
        rdc(UAS_OFF_ERR, 8'h02, "framing flag");
        rdc(UAS_OFF_RXB, 8'h5A, "framing data");
        wr(UAS_OFF_MODE, 8'hE0, r);
        rx_frame({3'b111, 7'h55, 1'b0}, 1'b1);
        rdc(UAS_OFF_ERR, 8'h00, "no parity");
        rdc(UAS_OFF_RXB, 8'h55, "seven bit data");
        // Two stop bits set, frames sent back to back with one
        wr(UAS_OFF_MODE, 8'hFE, r);
        rx_frame({1'b1, ^8'h11, 8'h11, 1'b0}, 1'b1);
        rx_frame({1'b1, ^8'h22, 8'h22, 1'b0}, 1'b1);
        rdc(UAS_OFF_ERR, 8'h01, "overrun flag");
        rdc(UAS_OFF_RXB, 8'h11, "overrun keeps");
        rx_frame({1'b1, ^8'h77, 8'h77, 1'b0}, 1'b1);
        wr(UAS_OFF_MODE, 8'h01, r);
        rdc(UAS_OFF_RXB, 8'h00, "power off buffer");
    endtask

    initial begin
        logic [1:0] r;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reg_checks();
        tx_case(8'hFC, 8'h55, 11, {1'b1, ^8'h55, 8'h55, 1'b0});
        tx_case(8'hF4, 8'hA7, 11, {1'b1, ~^8'hA7, 8'hA7, 1'b0});
        tx_case(8'hEC, 8'hFF, 11, {1'b1, 1'b0, 8'hFF, 1'b0});
        tx_case(8'hE2, 8'hB6, 10, {2'b11, 7'h36, 1'b0});
        tx_case(8'hE4, 8'h87, 10, {1'b1, 8'h87, 1'b0});
        wr(UAS_OFF_BAUD, 8'h82, r);
        tx_case(8'hFC, 8'h3C, 11, {1'b1, ^8'h3C, 8'h3C, 1'b0});
        wr(UAS_OFF_BAUD, 8'h08, r);
        tx_case(8'hFC, 8'hC3, 11, {1'b1, ^8'hC3, 8'hC3, 1'b0});
        rx_tests();
        report_and_stop();
    end
endmodule
